// File: rtl/rdp_defines.svh
`ifndef RDP_DEFINES_SVH
`define RDP_DEFINES_SVH
// register byte offsets
`define RDP_OFS_OPT1 12'h000
`define RDP_OFS_FRST 12'h004
`define RDP_OFS_CLK2 12'h008
`define RDP_OFS_PDIR 12'h00C
`define RDP_OFS_POUT 12'h010
`define RDP_OFS_PPUE 12'h014
`define RDP_OFS_PDSE 12'h018
`define RDP_OFS_PSLE 12'h01C
`define RDP_OFS_PIN 12'h020
`define RDP_OFS_STAT 12'h024
`define RDP_OFS_ALT 12'h028
// system_options_1 fields
`define RDP_OPT1_RSTPIN 0
`define RDP_OPT1_DBGPIN 1
`define RDP_OPT1_RESET 2'h2
// debug_force_reset_reg field
`define RDP_FRST_BIT 0
// clock_source_control_2 fields
`define RDP_CLK2_RANGE 0
`define RDP_CLK2_EXTCLK 1
`define RDP_CLK2_RESET 2'h0
// port pins: 14 pins, index 4 = debug pin, 5 = reset pin, 13 = output only
`define RDP_NPIN 14
`define RDP_PIN_DBG 4
`define RDP_PIN_RST 5
`define RDP_PIN_OUTONLY 13
// output-only pin presets: low drive, slew on
`define RDP_PDSE_RESET 14'h0000
`define RDP_PSLE_RESET 14'h2000
// clock reset figures
`define RDP_ICS_MHZ 16
`define RDP_BUS_DIV 4
// debug protocol bit time in debug clocks
`define RDP_BIT_CYC 16
// reset pin low filter in cycles
`define RDP_RST_FILT 4'h3
// mode codes
`define RDP_MODE_NORMAL 1'b0
`define RDP_MODE_BDM 1'b1
`endif

// File: rtl/rdp_pkg.sv
package rdp_pkg;
  // bus request captured in address phase
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
  } rdp_req_t;
  // pin drive of all 14 pads
  typedef struct packed {
    logic [13:0] o;
    logic [13:0] oe;
    logic [13:0] pu;
  } rdp_pad_t;
  // reset causes
  typedef enum logic [1:0] {
    RDP_RC_POR = 2'h0,
    RDP_RC_FRC = 2'h1,
    RDP_RC_PIN = 2'h2,
    RDP_RC_OTH = 2'h3
  } rdp_cause_t;
endpackage

// File: rtl/rdp_sync.sv
`timescale 1ns/10ps
`default_nettype none
// three-stage pin synchroniser; output moves only when stages 2 and 3 agree
module rdp_sync (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [13:0] din,
  output logic [13:0] dout
);
  logic [13:0] s1;
  logic [13:0] s2;
  logic [13:0] s3;
  wire [13:0] agree = ~(s2 ^ s3);
  wire [13:0] next_dout = (agree & s3) | (~agree & dout);
  // synchroniser chain, s1 read only by s2
  always_ff @(posedge mclk) begin
    if (srst) begin
      s1 <= 14'h3FFF;
      s2 <= 14'h3FFF;
      s3 <= 14'h3FFF;
      dout <= 14'h3FFF;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule
`default_nettype wire

// File: rtl/rdp_pin_config.sv
// Summary of operation
// - after power-on the shared pin is input
// - reset pin enable sticks until power-on
// - low on enabled reset pin resets device
// - reset pin pullup forced while enabled
// - debug pin samples mode during reset
// - debug pin enable set on every reset
// - debug pin pullup forced while enabled, off while driving
// - high mode pin gives normal mode
// - debug bit time is sixteen clocks
// - debug pin pseudo open drain, speedup
// - pin reset always returns to user mode
// - force reset with mode low enters debug
// - reset clock is internal, bus divided
// - range bit picks oscillator range, extclock
// - drive strength, slew and pullup per pin
// - after reset all pins input, pullups off except debug pin and enabled reset pin
// - output-only pin preset low drive, slew
// - highest priority function owns the pin
// - pullup off for outputs, and for analog except forced debug and reset pin pullups
`timescale 1ns/10ps
`default_nettype none
`include "rdp_defines.svh"
module rdp_pin_config (
  input wire logic mclk,
  input wire logic srst,
  input wire logic por,
  input wire logic sys_reset_req,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [13:0] pad_in,
  output logic [13:0] pad_out,
  output logic [13:0] pad_oe,
  output logic [13:0] pad_pullup,
  output logic [13:0] pad_high_drive,
  output logic [13:0] pad_slew,
  input wire logic dbg_tx_en,
  input wire logic dbg_tx_bit,
  input wire logic dbg_cmd_seen,
  input wire logic [13:0] periph_oe,
  input wire logic [13:0] periph_out,
  input wire logic [13:0] analog_en,
  input wire logic comp_out_en,
  input wire logic comp_out,
  output logic dbg_rx_bit,
  output logic dbg_bit_tick,
  output logic reset_out,
  output logic bdm_mode,
  output logic osc_range_high,
  output logic ext_clock_sel,
  output logic bus_clk_en
);
  // ***************************************
  // bus slave
  // ***************************************
  rdp_pkg::rdp_req_t req; // captured address phase
  logic req_valid; // data phase pending
  wire take = hsel & hready & htrans[1]; // nonseq or seq
  wire wr_ph = req_valid & req.wr; // write data phase
  // always one-cycle, OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // address phase capture
  always_ff @(posedge mclk) begin
    if (srst) begin
      req <= '0;
      req_valid <= 1'b0;
    end else begin
      req_valid <= take;
      req <= take ? rdp_pkg::rdp_req_t'{wr: hwrite, addr: haddr[11:0]} : req;
    end
  end
  // decode helper used for each write strobe
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction
  wire we_opt1 = wr_ph & hit(req.addr, `RDP_OFS_OPT1);
  wire we_frst = wr_ph & hit(req.addr, `RDP_OFS_FRST);
  wire we_clk2 = wr_ph & hit(req.addr, `RDP_OFS_CLK2);
  wire we_pdir = wr_ph & hit(req.addr, `RDP_OFS_PDIR);
  wire we_pout = wr_ph & hit(req.addr, `RDP_OFS_POUT);
  wire we_ppue = wr_ph & hit(req.addr, `RDP_OFS_PPUE);
  wire we_pdse = wr_ph & hit(req.addr, `RDP_OFS_PDSE);
  wire we_psle = wr_ph & hit(req.addr, `RDP_OFS_PSLE);
  wire we_alt = wr_ph & hit(req.addr, `RDP_OFS_ALT);
  // ***************************************
  // reset sequencing
  // ***************************************
  logic rst_pin_en; // sticky until power-on
  logic dbg_pin_en; // debug function claim
  logic bdm_q; // mode latched at reset release
  logic force_rst; // debug force reset request
  logic [3:0] rst_cnt; // reset pin low filter
  logic mode_lvl; // mode pin level while in reset
  rdp_pkg::rdp_cause_t cause;
  logic [13:0] pin_s; // synchronised pads
  rdp_sync u_sync (
    .mclk(mclk),
    .srst(srst),
    .din(pad_in),
    .dout(pin_s)
  );
  wire pin_low = rst_pin_en & ~pin_s[`RDP_PIN_RST];
  wire pin_reset = (rst_cnt == `RDP_RST_FILT);
  // force reset only after a debug command
  wire force_go = we_frst & hwdata[`RDP_FRST_BIT] & dbg_cmd_seen;
  wire any_reset = por | pin_reset | force_rst | sys_reset_req;
  // the chip reset goes out so the rest of the device restarts
  assign reset_out = any_reset;
  // filter on the reset pin keeps glitches from resetting us
  always_ff @(posedge mclk) begin
    if (srst | ~pin_low) begin
      rst_cnt <= 4'h0;
    end else if (~pin_reset) begin
      rst_cnt <= rst_cnt + 4'h1;
    end
  end
  // cause capture; pin reset cannot pick debug mode
  always_ff @(posedge mclk) begin
    if (srst) begin
      cause <= rdp_pkg::RDP_RC_POR;
      force_rst <= 1'b0;
      mode_lvl <= 1'b1;
    end else begin
      force_rst <= force_go;
      if (por) begin
        cause <= rdp_pkg::RDP_RC_POR;
      end else if (force_rst) begin
        cause <= rdp_pkg::RDP_RC_FRC;
      end else if (pin_reset) begin
        cause <= rdp_pkg::RDP_RC_PIN;
      end else if (sys_reset_req) begin
        cause <= rdp_pkg::RDP_RC_OTH;
      end
      if (any_reset) begin
        mode_lvl <= pin_s[`RDP_PIN_DBG];
      end
    end
  end
  // track reset release edge
  logic in_rst;
  always_ff @(posedge mclk) begin
    if (srst) begin
      in_rst <= 1'b1;
    end else begin
      in_rst <= any_reset;
    end
  end
  wire release_edge = in_rst & ~any_reset;
  wire mode_cause = (cause == rdp_pkg::RDP_RC_POR) | (cause == rdp_pkg::RDP_RC_FRC);
  // high mode level gives normal mode
  // pin and other resets give user mode
  wire next_bdm = (mode_cause & (mode_lvl == 1'b0)) ? `RDP_MODE_BDM : `RDP_MODE_NORMAL;
  always_ff @(posedge mclk) begin
    if (srst) begin
      bdm_q <= `RDP_MODE_NORMAL;
    end else if (release_edge) begin
      bdm_q <= next_bdm;
    end
  end
  assign bdm_mode = bdm_q;
  // ***************************************
  // option registers
  // ***************************************
  logic [1:0] clk2; // clock source control
  // reset pin claim, cleared only by power-on
  // debug pin claim set by any reset
  always_ff @(posedge mclk) begin
    if (srst | por) begin
      rst_pin_en <= 1'b0;
      dbg_pin_en <= 1'b1;
    end else if (any_reset) begin
      dbg_pin_en <= 1'b1;
    end else if (we_opt1) begin
      rst_pin_en <= rst_pin_en | hwdata[`RDP_OPT1_RSTPIN];
      dbg_pin_en <= hwdata[`RDP_OPT1_DBGPIN];
    end
  end
  always_ff @(posedge mclk) begin
    if (srst | any_reset) begin
      clk2 <= `RDP_CLK2_RESET;
    end else if (we_clk2) begin
      clk2 <= hwdata[1:0];
    end
  end
  assign osc_range_high = clk2[`RDP_CLK2_RANGE];
  assign ext_clock_sel = clk2[`RDP_CLK2_EXTCLK];
  // ***************************************
  // bus clock enable
  // ***************************************
  // internal source divided for bus rate
  logic [1:0] bdiv;
  always_ff @(posedge mclk) begin
    if (srst) begin
      bdiv <= 2'h0;
    end else begin
      bdiv <= bdiv + 2'h1;
    end
  end
  assign bus_clk_en = (bdiv == 2'(`RDP_BUS_DIV - 1));
  // ***************************************
  // debug bit timing
  // ***************************************
  logic [3:0] bit_cnt;
  always_ff @(posedge mclk) begin
    if (srst | ~dbg_pin_en) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end
  assign dbg_bit_tick = dbg_pin_en & (bit_cnt == 4'(`RDP_BIT_CYC - 1));
  // speedup pulse on the first clock of a released-high bit
  wire speedup = dbg_tx_en & dbg_tx_bit & (bit_cnt == 4'h0);
  assign dbg_rx_bit = pin_s[`RDP_PIN_DBG];
  // ***************************************
  // port control
  // ***************************************
  logic [13:0] pdir, pout, ppue, pdse, psle, alt;
  always_ff @(posedge mclk) begin
    if (srst | any_reset) begin
      pdir <= 14'h0000;
      pout <= 14'h0000;
      ppue <= 14'h0000;
      pdse <= `RDP_PDSE_RESET;
      psle <= `RDP_PSLE_RESET;
      alt <= 14'h0000;
    end else begin
      // per pin drive, slew and pullup
      pdir <= we_pdir ? hwdata[13:0] : pdir;
      pout <= we_pout ? hwdata[13:0] : pout;
      ppue <= we_ppue ? hwdata[13:0] : ppue;
      pdse <= we_pdse ? hwdata[13:0] : pdse;
      psle <= we_psle ? hwdata[13:0] : psle;
      alt <= we_alt ? hwdata[13:0] : alt;
    end
  end
  // general pins: peripheral output takes over port output
  // priority: port < alt < comparator < debug < mode, reset over all
  wire [13:0] base_oe = (alt & periph_oe) | (~alt & pdir);
  wire [13:0] base_o = (alt & periph_out) | (~alt & pout);
  wire dbg_in_mode = any_reset | in_rst; // mode-select phase, input only
  // pseudo open drain with speedup pulse
  wire dbg_drv = dbg_tx_en & (~dbg_tx_bit | speedup);
  wire dbg_oe = dbg_in_mode ? 1'b0 : dbg_pin_en ? dbg_drv : comp_out_en ? 1'b1 : base_oe[`RDP_PIN_DBG];
  wire dbg_o = dbg_pin_en ? speedup : comp_out_en ? comp_out : base_o[`RDP_PIN_DBG];
  wire rst_oe = rst_pin_en ? 1'b0 : base_oe[`RDP_PIN_RST];
  wire [13:0] oe_all = {base_oe[13:6], rst_oe, dbg_oe, base_oe[3:0]};
  wire [13:0] o_all = {base_o[13:6], base_o[5], dbg_o, base_o[3:0]};
  // pullup off on outputs and analog
  wire [13:0] pu_gen = ppue & ~oe_all & ~analog_en;
  wire pu_rst = rst_pin_en | pu_gen[`RDP_PIN_RST];
  wire pu_dbg = (dbg_pin_en & ~dbg_oe) | pu_gen[`RDP_PIN_DBG];
  rdp_pkg::rdp_pad_t pad;
  // pad outputs registered
  always_ff @(posedge mclk) begin
    if (srst) begin
      pad <= '0;
    end else begin
      pad.o <= o_all;
      pad.oe <= oe_all;
      pad.pu <= {pu_gen[13:6], pu_rst, pu_dbg, pu_gen[3:0]};
    end
  end
  assign pad_out = pad.o;
  assign pad_oe = pad.oe;
  assign pad_pullup = pad.pu;
  assign pad_high_drive = pdse;
  assign pad_slew = psle;
  // ***************************************
  // read mux
  // ***************************************
  wire [11:0] ra = req.addr;
  wire [13:0] rd_stat = {10'h000, cause, bdm_q, rst_pin_en};
  wire [13:0] rsel =
    hit(ra, `RDP_OFS_OPT1) ? {12'h000, dbg_pin_en, rst_pin_en} :
    hit(ra, `RDP_OFS_CLK2) ? {12'h000, clk2} :
    hit(ra, `RDP_OFS_PDIR) ? pdir :
    hit(ra, `RDP_OFS_POUT) ? pout :
    hit(ra, `RDP_OFS_PPUE) ? ppue :
    hit(ra, `RDP_OFS_PDSE) ? pdse :
    hit(ra, `RDP_OFS_PSLE) ? psle :
    hit(ra, `RDP_OFS_PIN) ? pin_s :
    hit(ra, `RDP_OFS_STAT) ? rd_stat :
    hit(ra, `RDP_OFS_ALT) ? alt : 14'h0000;
  // read data registered is not possible with zero wait; drive from flops directly
  assign hrdata = (req_valid & ~req.wr) ? {18'h00000, rsel} : 32'h00000000;
endmodule
`default_nettype wire

// File: testbench/rdp_dbg_pod.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// debug pod and reset source
// ****
module rdp_dbg_pod (
  input wire logic mclk,
  input wire logic ms_low,
  input wire logic rst_low,
  input wire logic [13:0] pad_out,
  input wire logic [13:0] pad_oe,
  input wire logic [13:0] pad_pullup,
  output logic [1:0] pin_lvl
);
  // a released line with no pullup floats; toggle so it never looks stable
  logic flip;
  initial flip = 1'b0;
  always @(posedge mclk) begin
    flip <= ~flip;
  end
  // device drive wins, host pulls low, else pullup
  assign pin_lvl[0] = pad_oe[4] ? pad_out[4] : ms_low ? 1'b0 : pad_pullup[4] ? 1'b1 : flip;
  // reset source pulls the shared pin low
  assign pin_lvl[1] = pad_oe[5] ? pad_out[5] : rst_low ? 1'b0 : pad_pullup[5] ? 1'b1 : flip;
endmodule
`default_nettype wire

// File: testbench/rdp_pin_config_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// port checker
// ****
module rdp_pin_config_chk (
  input wire logic mclk,
  input wire logic srst,
  input wire logic por,
  input wire logic sys_reset_req,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [13:0] pad_out,
  input wire logic [13:0] pad_oe,
  input wire logic [13:0] pad_pullup,
  input wire logic [13:0] pad_high_drive,
  input wire logic [13:0] pad_slew,
  input wire logic dbg_tx_en,
  input wire logic dbg_bit_tick,
  input wire logic reset_out,
  input wire logic bdm_mode,
  input wire logic bus_clk_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // gap after a bit tick
  sequence quiet15;
    (!dbg_bit_tick) [*8] ##1 (!dbg_bit_tick) [*7];
  endsequence
  // gap after a bus enable
  sequence quiet3;
    (!bus_clk_en) [*3];
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  AST_RESET_SRC: assert property ((por || sys_reset_req) |-> reset_out) else $error("reset lost");
  AST_PU_OFF_OUT: assert property ((pad_oe & pad_pullup) == 14'h0000) else $error("pullup on output");
  AST_BIT_TIME: assert property (dbg_bit_tick |=> quiet15) else $error("bit tick early");
  AST_BUS_DIV: assert property (bus_clk_en |=> quiet3 ##1 bus_clk_en) else $error("bus divide");
  AST_PAD_IDLE: assert property ($past(srst) |-> pad_oe == 14'h0000 && pad_pullup == 14'h0000)
    else $error("pads not idle");
  AST_OUTONLY_PRESET: assert property ($past(srst) |-> pad_slew == 14'h2000 && pad_high_drive == 14'h0000)
    else $error("output pin preset");
  AST_MODE_AT_RESET: assert property ($changed(bdm_mode) |-> $past(reset_out) || $past(reset_out, 2))
    else $error("mode moved");
  AST_SPEEDUP_BRIEF: assert property (dbg_tx_en && pad_oe[4] && pad_out[4] |=> !(pad_oe[4] && pad_out[4]))
    else $error("high drive too long");
endmodule
bind rdp_pin_config rdp_pin_config_chk u_rdp_pin_config_chk (.mclk(mclk), .srst(srst), .por(por),
  .sys_reset_req(sys_reset_req), .hreadyout(hreadyout), .hresp(hresp), .pad_out(pad_out), .pad_oe(pad_oe),
  .pad_pullup(pad_pullup), .pad_high_drive(pad_high_drive), .pad_slew(pad_slew), .dbg_tx_en(dbg_tx_en),
  .dbg_bit_tick(dbg_bit_tick), .reset_out(reset_out), .bdm_mode(bdm_mode), .bus_clk_en(bus_clk_en));
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// bench top
// ****
module tb_top;
  logic mclk, srst, por, sys_reset_req, hwrite, hsel, dbg_tx_en, dbg_tx_bit, dbg_cmd_seen, comp_out;
  logic hreadyout, hresp, dbg_rx_bit, dbg_bit_tick, reset_out, bdm_mode, osc_range_high, ext_clock_sel;
  logic ms_low, rst_low, rd_dph;
  logic [1:0] htrans, pin_lvl;
  logic [31:0] haddr, hwdata, hrdata, r1, r2, r3;
  logic [13:0] rnd_in, periph_out, analog_en, pad_out, pad_oe, pad_pullup, pad_high_drive, pad_slew;
  logic [31:0] expq[$];
  int fail_count, total_checks, n;
  localparam logic [31:0] RA[7] = '{32'h00, 32'h08, 32'h0C, 32'h14, 32'h18, 32'h1C, 32'h3C};
  localparam logic [31:0] DF[7] = '{32'h2, 32'h0, 32'h0, 32'h0, 32'h0, 32'h2000, 32'h0};
  localparam logic [31:0] ST[3] = '{32'h0, 32'h2, 32'hC};
  localparam logic [13:0] M = 14'h1FDF;
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  rdp_pin_config u_rdp_pin_config (.mclk(mclk), .srst(srst), .por(por), .sys_reset_req(sys_reset_req),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hsel(hsel), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pad_in({rnd_in[13:6], pin_lvl, rnd_in[3:0]}), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .pad_high_drive(pad_high_drive), .pad_slew(pad_slew), .dbg_tx_en(dbg_tx_en),
    .dbg_tx_bit(dbg_tx_bit), .dbg_cmd_seen(dbg_cmd_seen), .periph_oe(14'h0000), .periph_out(periph_out),
    .analog_en(analog_en), .comp_out_en(1'b0), .comp_out(comp_out), .dbg_rx_bit(dbg_rx_bit),
    .dbg_bit_tick(dbg_bit_tick), .reset_out(reset_out), .bdm_mode(bdm_mode),
    .osc_range_high(osc_range_high), .ext_clock_sel(ext_clock_sel), .bus_clk_en());
  rdp_dbg_pod u_rdp_dbg_pod (.mclk(mclk), .ms_low(ms_low), .rst_low(rst_low), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup(pad_pullup), .pin_lvl(pin_lvl));
  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one single word transfer, each phase held until hready
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  // bounded wait for the reset line to reach a level
  task automatic wait_rst(input logic v);
    n = 0;
    while (reset_out !== v && n < 60) begin
      @(negedge mclk);
      n++;
    end
    chk(32'(reset_out), 32'(v));
    @(posedge mclk);
  endtask
  // read data is taken at the edge closing the data phase
  always @(posedge mclk) begin
    if (rd_dph === 1'b1) begin
      chk(hrdata, expq.pop_front());
    end
    rd_dph <= hsel && htrans[1] && !hwrite && !srst;
  end
  // noise on pins and peripheral lines nobody owns
  always @(posedge mclk) begin
    rnd_in <= 14'($urandom);
    periph_out <= 14'($urandom);
    comp_out <= 1'($urandom);
  end
  initial begin
    #1000000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    {srst, por, sys_reset_req, hwrite, hsel, dbg_tx_en, dbg_tx_bit, dbg_cmd_seen} = 8'h80;
    {ms_low, rst_low, htrans, haddr, hwdata} = '0;
    analog_en = '0;
    void'($urandom(20757));
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(32'(pad_pullup[5:4]), 32'h1);
    xfer(1'b1, 32'h3C, 32'hFFFF);
    for (int i = 0; i < 7; i++) rd(RA[i], DF[i]);
    xfer(1'b1, 32'h08, 32'h3);
    repeat (2) @(posedge mclk);
    chk(32'({osc_range_high, ext_clock_sel}), 32'h3);
    tick_gap();
    chk(n, 16);
    dbg_tx_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      dbg_tx_bit <= i[0];
      repeat (12) @(posedge mclk);
      chk(32'({pin_lvl[0], dbg_rx_bit}), i[0] ? 32'h3 : 32'h0);
      repeat (4) @(posedge mclk);
    end
    dbg_tx_en <= 1'b0;
    r1 = $urandom;
    r2 = $urandom;
    r3 = $urandom;
    analog_en <= 14'($urandom);
    xfer(1'b1, 32'h00, 32'h1);
    xfer(1'b1, 32'h14, r1);
    xfer(1'b1, 32'h0C, r2);
    xfer(1'b1, 32'h18, r3);
    xfer(1'b1, 32'h1C, ~r3);
    repeat (4) @(posedge mclk);
    chk(32'(pad_oe & M), 32'(r2[13:0] & M));
    chk(32'(pad_pullup & M), 32'(r1[13:0] & ~r2[13:0] & ~analog_en & M));
    chk({pad_high_drive, pad_slew}, {r3[13:0], ~r3[13:0]});
    chk(32'(pad_pullup[5]), 32'h1);
    xfer(1'b1, 32'h00, 32'h0);
    rd(32'h00, 32'h1);
    ms_low <= 1'b1;
    rst_low <= 1'b1;
    wait_rst(1'b1);
    repeat (4) @(posedge mclk);
    rst_low <= 1'b0;
    wait_rst(1'b0);
    repeat (4) @(posedge mclk);
    chk(32'(bdm_mode), 32'h0);
    rd(32'h24, 32'h9);
    rd(32'h00, 32'h3);
    xfer(1'b1, 32'h04, 32'h1);
    repeat (3) @(posedge mclk);
    chk(32'(reset_out), 32'h0);
    dbg_cmd_seen <= 1'b1;
    xfer(1'b1, 32'h04, 32'h1);
    wait_rst(1'b1);
    wait_rst(1'b0);
    repeat (4) @(posedge mclk);
    dbg_cmd_seen <= 1'b0;
    chk(32'(bdm_mode), 32'h1);
    rd(32'h24, 32'h7);
    for (int k = 0; k < 3; k++) begin
      ms_low <= (k != 0);
      // let the mode pin settle through the pad synchroniser before reset
      repeat (6) @(posedge mclk);
      por <= (k != 2);
      sys_reset_req <= (k == 2);
      repeat (4) @(posedge mclk);
      por <= 1'b0;
      sys_reset_req <= 1'b0;
      wait_rst(1'b0);
      repeat (4) @(posedge mclk);
      ms_low <= 1'b0;
      chk(32'(bdm_mode), 32'(k == 1));
      rd(32'h24, ST[k]);
      rd(32'h00, 32'h2);
    end
    repeat (2) @(posedge mclk);
    tally_and_finish();
  end
  // cycles between two bit ticks, counted at falling edges
  task automatic tick_gap();
    n = 0;
    while (dbg_bit_tick !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (dbg_bit_tick !== 1'b1 && n < 40);
    @(posedge mclk);
  endtask
endmodule
`default_nettype wire
